// >>> common/fecc_consts.vh
// constants for the ecc error-tracking block
`ifndef FECC_CONSTS_VH
`define FECC_CONSTS_VH
// command opcodes
`define FECC_OP_UNIT_READ 8'h19
`define FECC_OP_CLEAR 8'h1b
`define FECC_OP_REG_READ 8'h65
// lane modes
`define FECC_LANE_SINGLE 2'h0
`define FECC_LANE_DUAL 2'h1
`define FECC_LANE_QUAD 2'h2
// phase lengths in bits
`define FECC_CMD_BITS 6'h08
`define FECC_ADDR_BITS 6'h18
// register addresses for the generic register read
`define FECC_RA_STATUS 24'h000100
`define FECC_RA_COUNT 24'h000101
`define FECC_RA_TRAP 24'h000102
// field positions and limits
`define FECC_STATUS_FLAG_BIT 4
`define FECC_UNIT_FLAG_BIT 3
`define FECC_UNIT_LSB 3
`define FECC_COUNT_MAX 16'hffff
// reset values
`define FECC_STATUS_RST 8'h00
`define FECC_COUNT_RST 16'h0000
`define FECC_TRAP_RST 32'h00000000
`endif

// >>> logic/fecc_top.v
// ecc error tracking and command handling behind the serial pins
// Overview of operation
// - status register only via generic register read
// - tracking works on aligned eight-byte units
// - status bit 4 sticky double error flag
// - clear command zeroes double error flag
// - 16-bit counter counts double errors on reads
// - counter saturates at all ones
// - counter zero after reset and power-down exit
// - clear zeroes flags, trap and counter
// - trap holds first failing unit address
// - later errors only bump counter
// - trap reads zero after power-down exit
// - decode unit read and clear opcodes
// - ignore three low address bits
// - wait latency dummies, then shift status byte
// - bytes past status byte are don't-care
// - unit status bit 3 flags double error
// - clear needs no write enable latch
// - unit read of bad unit sets flag
// - single-bit errors never reported
// - special sector and registers not tracked
`timescale 1ns/100ps
`include "fecc_consts.vh"
module fecc_top (
  input wire clock,                // system clock, 10 MHz
  input wire rst,                  // synchronous reset, active high
  input wire ce,                   // clock enable, freezes state when low
  input wire spi_sck,              // serial clock pin
  input wire spi_cs_n,             // chip select pin, active low
  input wire [3:0] spi_io_in,      // data pins, input side
  output reg [3:0] spi_io_out,     // data pins, output side
  output reg [3:0] spi_io_oe,      // data pins, output enable
  input wire [1:0] lane_mode,      // single, dual or quad protocol
  input wire ddr_mode,             // double data rate selected
  input wire [3:0] latency_code,   // dummy cycles from config_register_one
  input wire dbl_err_det,          // pulse: double error on array read
  input wire [23:0] dbl_err_addr,  // byte address of that read
  input wire dbl_err_special,      // error came from a non-tracked region
  input wire dpd_exit,             // pulse: leaving deep_power_down
  output reg unit_query_req,       // pulse: ask array for unit state
  output reg [20:0] unit_query_addr, // unit index being queried
  input wire unit_query_dbl,       // addressed unit holds double error
  output reg [7:0] ecc_status,     // status register image
  output reg [15:0] double_error_count, // double error counter
  output reg [31:0] first_error_address_trap // first failing unit
);

  localparam ST_CMD = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_DUMMY = 3'h2;
  localparam ST_DATA = 3'h3;
  localparam ST_IGNORE = 3'h4;

  localparam OP_NONE = 2'h0;
  localparam OP_UNIT = 2'h1;
  localparam OP_REG = 2'h2;
  localparam OP_CLR = 2'h3;

  // pin synchronisers: first stage read only by second stage
  reg [5:0] pin_s1_r;
  reg [5:0] pin_s2_r;
  reg sck_d_r;
  reg cs_n_d_r;
  wire sck_s = pin_s2_r[5];
  wire cs_n_s = pin_s2_r[4];
  wire [3:0] io_s = pin_s2_r[3:0];
  wire sck_rise = sck_s & ~sck_d_r;
  wire sck_fall = ~sck_s & sck_d_r;
  wire cs_rise = cs_n_s & ~cs_n_d_r;

  always @(posedge clock) begin
    if (rst) begin
      pin_s1_r <= 6'h30;
      pin_s2_r <= 6'h30;
      sck_d_r <= 1'b1;
      cs_n_d_r <= 1'b1;
    end else if (ce) begin
      pin_s1_r <= {spi_sck, spi_cs_n, spi_io_in};
      pin_s2_r <= pin_s1_r;
      sck_d_r <= sck_s;
      cs_n_d_r <= cs_n_s;
    end
  end

  reg [2:0] st_r;
  reg [1:0] op_r;
  reg [5:0] cnt_r;
  reg [3:0] dummy_r;
  reg [31:0] in_sr_r;
  reg [31:0] out_sr_r;
  reg first_r;
  reg flag_r;
  reg trap_full_r;

  // bits moved per clock edge and the shifted input word
  reg [5:0] wbits;
  reg [31:0] in_sr_nxt;
  always @* begin
    case (lane_mode)
      `FECC_LANE_DUAL: begin
        wbits = 6'h02;
        in_sr_nxt = {in_sr_r[29:0], io_s[1:0]};
      end
      `FECC_LANE_QUAD: begin
        wbits = 6'h04;
        in_sr_nxt = {in_sr_r[27:0], io_s};
      end
      default: begin
        wbits = 6'h01;
        in_sr_nxt = {in_sr_r[30:0], io_s[0]};
      end
    endcase
  end

  wire [5:0] cnt_nxt = cnt_r + wbits;
  wire [3:0] dummy_nxt = dummy_r + 4'h1;

  reg [31:0] reg_word;
  always @* begin
    case (in_sr_r[23:0])
      `FECC_RA_STATUS: reg_word = {ecc_status, 24'h000000};
      `FECC_RA_COUNT: reg_word = {double_error_count, 16'h0000};
      `FECC_RA_TRAP: reg_word = first_error_address_trap;
      default: reg_word = 32'h00000000;
    endcase
  end

  // unit status byte, only bit 3 can be set
  wire [7:0] unit_byte = {4'h0, unit_query_dbl, 3'h0};
  wire [31:0] load_word = (op_r == OP_UNIT) ?
    {unit_byte, 24'h000000} : reg_word;
  wire [31:0] cur_word = first_r ? load_word : out_sr_r;

  // word left after this edge; zeros trail so extra bytes read zero
  reg [31:0] shifted_word;
  reg [3:0] drive_bits;
  reg [3:0] drive_oe;
  always @* begin
    case (lane_mode)
      `FECC_LANE_DUAL: begin
        shifted_word = {cur_word[29:0], 2'h0};
        drive_bits = {2'h0, cur_word[31:30]};
        drive_oe = 4'h3;
      end
      `FECC_LANE_QUAD: begin
        shifted_word = {cur_word[27:0], 4'h0};
        drive_bits = cur_word[31:28];
        drive_oe = 4'hf;
      end
      default: begin
        shifted_word = {cur_word[30:0], 1'h0};
        drive_bits = {2'h0, cur_word[31], 1'h0};
        drive_oe = 4'h2;
      end
    endcase
  end

  // status fetched during the first output edge of a unit read
  wire unit_read_hit = ce & sck_fall & ~cs_n_s & (st_r == ST_DATA) &
    first_r & (op_r == OP_UNIT) & unit_query_dbl;
  // clear runs at select release, no latch check
  wire clr_cmd = ce & cs_rise & (op_r == OP_CLR);

  // command sequencer on synchronised pin edges
  always @(posedge clock) begin
    if (rst) begin
      st_r <= ST_CMD;
      op_r <= OP_NONE;
      cnt_r <= 6'h00;
      dummy_r <= 4'h0;
      in_sr_r <= 32'h00000000;
      out_sr_r <= 32'h00000000;
      first_r <= 1'b0;
      spi_io_out <= 4'h0;
      spi_io_oe <= 4'h0;
      unit_query_req <= 1'b0;
      unit_query_addr <= 21'h000000;
    end else if (ce) begin
      unit_query_req <= 1'b0;
      if (cs_n_s) begin
        // deselect ends any command and frees the pins
        st_r <= ST_CMD;
        op_r <= OP_NONE;
        cnt_r <= 6'h00;
        first_r <= 1'b0;
        spi_io_oe <= 4'h0;
      end else if (sck_rise) begin
        case (st_r)
          ST_CMD: begin
            in_sr_r <= in_sr_nxt;
            cnt_r <= cnt_nxt;
            if (cnt_nxt == `FECC_CMD_BITS) begin
              cnt_r <= 6'h00;
              st_r <= ST_IGNORE;
              // double data rate forms never accepted
              if (!ddr_mode) begin
                case (in_sr_nxt[7:0])
                  `FECC_OP_UNIT_READ: begin
                    op_r <= OP_UNIT;
                    st_r <= ST_ADDR;
                  end
                  `FECC_OP_REG_READ: begin
                    op_r <= OP_REG;
                    st_r <= ST_ADDR;
                  end
                  `FECC_OP_CLEAR: op_r <= OP_CLR;
                  default: op_r <= OP_NONE;
                endcase
              end
            end
          end
          ST_ADDR: begin
            in_sr_r <= in_sr_nxt;
            cnt_r <= cnt_nxt;
            if (cnt_nxt == `FECC_ADDR_BITS) begin
              cnt_r <= 6'h00;
              dummy_r <= 4'h0;
              // low three bits dropped, unit index kept
              unit_query_addr <= in_sr_nxt[23:`FECC_UNIT_LSB];
              unit_query_req <= (op_r == OP_UNIT);
              // dummy phase length from latency code
              if (latency_code == 4'h0) begin
                st_r <= ST_DATA;
                first_r <= 1'b1;
              end else begin
                st_r <= ST_DUMMY;
              end
            end
          end
          ST_DUMMY: begin
            dummy_r <= dummy_nxt;
            if (dummy_nxt == latency_code) begin
              st_r <= ST_DATA;
              first_r <= 1'b1;
            end
          end
          default: begin
            cnt_r <= cnt_r;
          end
        endcase
      end else if (sck_fall && st_r == ST_DATA) begin
        // status shifted out most significant first
        // no auto-increment, later bits shift zeros
        first_r <= 1'b0;
        out_sr_r <= shifted_word;
        spi_io_out <= drive_bits;
        spi_io_oe <= drive_oe;
      end
    end
  end

  // only double errors reach the tracking logic
  // errors from special sector or registers dropped
  wire det_ok = ce & dbl_err_det & ~dbl_err_special;
  wire wipe = clr_cmd | (ce & dpd_exit);

  // counter: a detection in a clearing cycle still counts
  reg [15:0] count_base;
  reg [15:0] count_nxt;
  always @* begin
    count_base = wipe ? `FECC_COUNT_RST : double_error_count;
    count_nxt = count_base;
    if (det_ok && count_base != `FECC_COUNT_MAX) begin
      count_nxt = count_base + 16'h0001;
    end
  end

  // tracking registers; a set beats a clear in the same cycle
  always @(posedge clock) begin
    if (rst) begin
      double_error_count <= `FECC_COUNT_RST;
      first_error_address_trap <= `FECC_TRAP_RST;
      trap_full_r <= 1'b0;
      flag_r <= 1'b0;
      ecc_status <= `FECC_STATUS_RST;
    end else if (ce) begin
      double_error_count <= count_nxt;
      // trap wiped on power-down exit or clear
      if (wipe) begin
        first_error_address_trap <= `FECC_TRAP_RST;
        trap_full_r <= 1'b0;
      end
      // stored address aligned to eight bytes
      if (det_ok && (wipe || !trap_full_r)) begin
        first_error_address_trap <=
          {8'h00, dbl_err_addr[23:`FECC_UNIT_LSB], 3'h0};
        trap_full_r <= 1'b1;
      end
      // unit read of failing unit also sets it
      if (det_ok || unit_read_hit) begin
        flag_r <= 1'b1;
      end else if (wipe) begin
        flag_r <= 1'b0;
      end
      ecc_status <= {3'h0,
        (det_ok | unit_read_hit) | (flag_r & ~wipe), 4'h0};
    end
  end

endmodule

// >>> verification/fecc_host.sv
// host serial controller model for the ecc block
`timescale 1ns/100ps
module fecc_host (
  output logic sck, // serial clock, still outside frames
  output logic cs_n, // select, active low
  output logic [3:0] d, // host data lines
  input wire [3:0] q // resolved pin level
);
  initial begin
    sck = 0;
    cs_n = 1;
    d = 4'h5;
  end
  // one command per frame, select raised after data
  task xfer(input int w, input [7:0] op, input int na, input [23:0] a,
    input int dm, input int nr, output logic [31:0] rd);
    logic [31:0] sh;
    int i;
    int k;
    sh = {op, a};
    rd = 0;
    #37 cs_n = 0;
    for (i = 0; i < 8 + na + dm * w + nr; i += w) begin
      // released lines toggle so a stale value never looks valid
      if (i < 8 + na)
        for (k = 0; k < w; k++) d[k] = sh[31 - i - w + 1 + k];
      else
        d = ~d;
      #400 sck = 1;
      if (i >= 8 + na + dm * w)
        for (k = w - 1; k >= 0; k--) rd = {rd[30:0], q[w == 1 ? 1 : k]};
      #400 sck = 0;
    end
    #400 cs_n = 1;
    d = ~d;
    #1600;
  endtask
endmodule

// >>> verification/fecc_sva.sv
// assertion checker for the ecc tracking block
`timescale 1ns/100ps
module fecc_sva (
  input wire clock, // system clock
  input wire rst, // sync reset
  input wire ce, // clock enable
  input wire spi_cs_n, // select pin
  input wire [3:0] spi_io_oe, // pin enables
  input wire ddr_mode, // ddr selected
  input wire dbl_err_det, // error pulse
  input wire [23:0] dbl_err_addr, // error address
  input wire dbl_err_special, // untracked region
  input wire dpd_exit, // power-down exit
  input wire unit_query_req, // unit query pulse
  input wire [7:0] ecc_status, // status image
  input wire [15:0] double_error_count, // counter
  input wire [31:0] first_error_address_trap // trap
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // counted events; power-down exit excluded since the counter restarts from zero there
  wire ev = ce & dbl_err_det & ~dbl_err_special & ~dpd_exit;
  wire [15:0] cnt = double_error_count;
  wire [31:0] trap = first_error_address_trap;
  wire [20:0] ua = dbl_err_addr[23:3];
  AST_CNT_INC:
    assert property (ev && cnt != 16'hffff |=> cnt == $past(cnt) + 16'h1)
    else $error("count did not step");
  AST_CNT_SAT:
    assert property (ev && cnt == 16'hffff |=> cnt == 16'hffff)
    else $error("count wrapped");
  AST_TRAP_CAP:
    assert property (ev && cnt == 16'h0 |=>
      trap == {8'h0, $past(ua), 3'h0} && ecc_status == 8'h10)
    else $error("first error not trapped");
  AST_TRAP_HOLD:
    assert property (ev && cnt != 16'h0 |=> $stable(trap))
    else $error("trap overwritten");
  AST_SPECIAL:
    assert property (ce && dbl_err_det && dbl_err_special && !dpd_exit
      && spi_cs_n |=> $stable(cnt))
    else $error("untracked error counted");
  AST_DPD:
    assert property (ce && dpd_exit && !dbl_err_det |=>
      cnt == 16'h0 && trap == 32'h0 && ecc_status == 8'h0)
    else $error("power-down exit left state");
  AST_RSVD:
    assert property (ecc_status[7:5] == 3'h0 && ecc_status[3:0] == 4'h0)
    else $error("reserved status bit set");
  AST_FLAG_CLR:
    assert property ($fell(ecc_status[4]) |-> spi_cs_n || $past(dpd_exit))
    else $error("flag dropped mid frame");
  AST_DDR:
    assert property (ddr_mode |-> spi_io_oe == 4'h0 && !unit_query_req)
    else $error("ddr command acted on");
  AST_OE_IDLE:
    assert property ((ce && spi_cs_n) [*4] |-> spi_io_oe == 4'h0)
    else $error("pins driven while deselected");
  AST_QREQ_ONE:
    assert property (unit_query_req |=> !unit_query_req)
    else $error("unit query longer than one cycle");
  cover property (ev && cnt == 16'hffff);
  cover property (unit_query_req);
  cover property ($fell(ecc_status[4]) && spi_cs_n);
endmodule
bind fecc_top fecc_sva chk (
  .clock(clock),
  .rst(rst),
  .ce(ce),
  .spi_cs_n(spi_cs_n),
  .spi_io_oe(spi_io_oe),
  .ddr_mode(ddr_mode),
  .dbl_err_det(dbl_err_det),
  .dbl_err_addr(dbl_err_addr),
  .dbl_err_special(dbl_err_special),
  .dpd_exit(dpd_exit),
  .unit_query_req(unit_query_req),
  .ecc_status(ecc_status),
  .double_error_count(double_error_count),
  .first_error_address_trap(first_error_address_trap)
);

// >>> verification/fecc_top_tb.sv
// self-checking bench for the ecc tracking block
`timescale 1ns/100ps
module fecc_top_tb;
  logic clock, rst, ce, ddr_mode, dbl_err_det, dbl_err_special, dpd_exit;
  logic unit_query_dbl = 0;
  logic [1:0] lane_mode;
  logic [3:0] latency_code;
  logic [23:0] dbl_err_addr;
  wire spi_sck, spi_cs_n, unit_query_req;
  wire [3:0] hd, spi_io_out, spi_io_oe, spi_io_in;
  wire [20:0] unit_query_addr;
  wire [7:0] ecc_status;
  wire [15:0] double_error_count;
  wire [31:0] first_error_address_trap;
  logic [31:0] rd;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  // pin level: the design wins where it drives
  assign spi_io_in = (spi_io_oe & spi_io_out) | (~spi_io_oe & hd);
  fecc_top dut (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n),
    .spi_io_in(spi_io_in),
    .spi_io_out(spi_io_out),
    .spi_io_oe(spi_io_oe),
    .lane_mode(lane_mode),
    .ddr_mode(ddr_mode),
    .latency_code(latency_code),
    .dbl_err_det(dbl_err_det),
    .dbl_err_addr(dbl_err_addr),
    .dbl_err_special(dbl_err_special),
    .dpd_exit(dpd_exit),
    .unit_query_req(unit_query_req),
    .unit_query_addr(unit_query_addr),
    .unit_query_dbl(unit_query_dbl),
    .ecc_status(ecc_status),
    .double_error_count(double_error_count),
    .first_error_address_trap(first_error_address_trap)
  );
  fecc_host host (.sck(spi_sck), .cs_n(spi_cs_n), .d(hd), .q(spi_io_in));
  initial begin
    clock = 0;
    forever #50 clock = ~clock;
  end
  // array side: only unit 0x40 holds a double error
  always @(posedge clock) unit_query_dbl <= (unit_query_addr == 21'h40);
  // hang guard, well above the ~68k cycles the run needs
  always @(posedge clock) begin
    cyc++;
    if (cyc == 90000) begin
      bad_count++;
      finish_test;
    end
  end
  task chk(string nm, logic [31:0] e, logic [31:0] g);
    #1 n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task pulse(input [23:0] a, input s);
    @(posedge clock);
    dbl_err_det <= 1;
    dbl_err_addr <= a;
    dbl_err_special <= s;
    @(posedge clock);
    dbl_err_det <= 0;
    @(posedge clock);
  endtask
  task t_err;
    chk("count", 0, double_error_count);
    pulse(24'h001234, 0);
    pulse(24'h00ff00, 0);
    pulse(24'h000800, 1);
    chk("count", 2, double_error_count);
    chk("trap", 32'h1230, first_error_address_trap);
    chk("status", 8'h10, ecc_status);
    // enable low: a held detection must not count
    @(posedge clock) ce <= 0;
    dbl_err_special <= 0;
    dbl_err_det <= 1;
    repeat (3) @(posedge clock);
    ce <= 1;
    dbl_err_det <= 0;
    @(posedge clock);
    chk("held count", 2, double_error_count);
    host.xfer(1, 8'h65, 24, 24'h000101, 0, 16, rd);
    chk("count rd", 16'h0002, rd);
    @(posedge clock) lane_mode <= 2;
    latency_code <= 3;
    host.xfer(4, 8'h65, 24, 24'h000102, 3, 32, rd);
    chk("trap rd", 32'h1230, rd);
    @(posedge clock) lane_mode <= 1;
    host.xfer(2, 8'h65, 24, 24'h000100, 3, 8, rd);
    chk("status rd", 8'h10, rd);
    host.xfer(2, 8'h65, 24, 24'h000000, 3, 8, rd);
    chk("unmapped rd", 8'h00, rd);
    $display("t_err done");
  endtask
  task t_clr;
    int m;
    @(posedge clock) ddr_mode <= 1;
    host.xfer(2, 8'h1b, 0, 0, 0, 0, rd);
    chk("ddr clear", 2, double_error_count);
    @(posedge clock) ddr_mode <= 0;
    for (m = 0; m < 3; m++) begin
      pulse(24'h000008, 0);
      @(posedge clock) lane_mode <= m[1:0];
      host.xfer(1 << m, 8'h1b, 0, 0, 0, 0, rd);
      chk("clr count", 0, double_error_count);
      chk("clr trap", 0, first_error_address_trap);
      chk("clr status", 0, ecc_status);
    end
    $display("t_clr done");
  endtask
  task t_unit;
    int m;
    for (m = 0; m < 3; m++) begin
      @(posedge clock) lane_mode <= m[1:0];
      latency_code <= m[3:0];
      host.xfer(1 << m, 8'h19, 24, 24'h000207, m, 8, rd);
      chk("unit bad", 8'h08, rd);
      chk("unit idx", 21'h40, unit_query_addr);
      chk("unit flag", 8'h10, ecc_status);
      host.xfer(1 << m, 8'h19, 24, 24'h000210, m, 8, rd);
      chk("unit ok", 8'h00, rd);
    end
    $display("t_unit done");
  endtask
  task t_sat;
    @(posedge clock) dbl_err_det <= 1;
    repeat (65536) @(posedge clock);
    dbl_err_det <= 0;
    @(posedge clock) dpd_exit <= 0;
    chk("sat", 16'hffff, double_error_count);
    @(posedge clock) dpd_exit <= 1;
    @(posedge clock) dpd_exit <= 0;
    @(posedge clock);
    chk("dpd count", 0, double_error_count);
    chk("dpd trap", 0, first_error_address_trap);
    $display("t_sat done");
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    rst = 1;
    ce = 1;
    ddr_mode = 0;
    dbl_err_det = 0;
    dbl_err_special = 0;
    dpd_exit = 0;
    lane_mode = 0;
    latency_code = 0;
    dbl_err_addr = 0;
    repeat (4) @(posedge clock);
    rst <= 0;
    repeat (4) @(posedge clock);
    t_err;
    t_clr;
    t_unit;
    t_sat;
    finish_test;
  end
endmodule
